// ---- logic/pin_glitch_catch.sv ----
/*
 * Catches a low-going pulse on the reset pin of any width as a sticky
 * request, then synchronises it. Assumes the pin idles high.
 */
module pin_glitch_catch (
    input  wire logic mclk_i,
    input  wire logic rst_i,
    input  wire logic pin_n_i,
    input  wire logic ack_i,
    output logic      seen_o
);

    logic catch_reg;
    logic meta_reg;
    logic sync_reg;
    logic meta_next;
    logic sync_next;

    // ------------------------------------------------------------
    // Sticky catch of any falling edge
    // ------------------------------------------------------------
    always_ff @(negedge pin_n_i or posedge ack_i or posedge rst_i) begin
        if (rst_i) begin
            catch_reg <= 1'b0;
        end else if (ack_i) begin
            catch_reg <= 1'b0;
        end else begin
            catch_reg <= 1'b1; // [R6]
        end
    end

    always_comb begin
        meta_next = catch_reg;
        sync_next = meta_reg;
    end

    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            meta_reg <= 1'b0;
            sync_reg <= 1'b0;
        end else begin
            meta_reg <= meta_next; // [R25]
            sync_reg <= sync_next;
        end
    end

    assign seen_o = sync_reg;

endmodule

// ---- logic/power_mgmt_map.svh ----
/*
 * Offsets-free constants for the suspend/sleep power management unit:
 * configuration byte field positions, reset values and timing counts.
 * Assumes a 100 MHz system clock and inclusion by bare name.
 */
// Behaviour
// [R1] Suspend request gates system clock and disables internal oscillators.
// [R2] Firmware selects an internal oscillator before suspend or sleep.
// [R3] While suspended logic halts until an enabled wake source fires.
// [R4] Four wake sources: osc fail, alarm, port match, comparator rise.
// [R5] Wake flags read zero for two clocks after leaving suspend.
// [R6] Short low glitch on reset pin still ends suspend.
// [R7] After pin wake firmware waits 15 us before re-entering low power.
// [R8] Sleep turns off core regulator, RAM moves to battery supply.
// [R9] In two-cell sleep only comparators stay on; firmware disables others.
// [R10] Firmware places four no-ops after the sleep write.
// [R11] Short active intervals: enable all wake sources or bypass one-shot.
// [R12] Digital output pins hold their level during sleep.
// [R13] Digital input pins stay usable as port match wake sources.
// [R14] Wake request output low while asleep, high while awake.
// [R15] Sleep rail float bit set leaves analog rail floating in sleep.
// [R16] Sleep preserves RAM, registers, program counter and volatile state.
// [R17] Comparator wake from sleep works only in two-cell mode.
// [R18] Monitor-off bit disables battery monitor; any reset forces full POR.
// [R19] Enable bits written with the same write that requests low power.
// [R20] Reset pin always wakes; pin reset acts if awake over 15 us.
// [R21] Wake flags record events always, enabled or not.
// [R22] Entry blocked while any enabled wake flag is set.
// [R23] Config bits: 7 sleep, 6 suspend, 5 clear, 4 pin flag, 3..0.
// [R24] Enable-and-flag bits take enable on write, return flag on read.
// [R25] Asynchronous wake events are synchronised before use.
`ifndef POWER_MGMT_MAP_SVH
`define POWER_MGMT_MAP_SVH

`define CFG_SLEEP_BIT     7
`define CFG_SUSPEND_BIT   6
`define CFG_CLEAR_BIT     5
`define CFG_PIN_FLAG_BIT  4
`define CFG_RESET_VALUE   8'h00
`define WAKE_BLANK_CYCLES 2
`define PIN_HOLD_NS       15000
`define CLK_PERIOD_NS     10
`define PIN_HOLD_CYCLES   ((`PIN_HOLD_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// ---- logic/power_mgmt_pkg.sv ----
/*
 * Types for the power management unit.
 * Assumes the map header is compiled alongside.
 */
package power_mgmt_pkg;

    typedef enum logic [1:0] {
        MODE_RUN,
        MODE_SUSPEND,
        MODE_SLEEP
    } power_mode_e;

    typedef struct packed {
        logic osc_fail;
        logic alarm;
        logic port_match;
        logic comparator;
    } wake_src_s;

    typedef struct packed {
        logic sleep;
        logic suspend;
        logic clear;
        logic [3:0] enable;
    } cfg_write_s;

endpackage

// ---- logic/power_mgmt_unit.sv ----
/*
 * Suspend and sleep control: wake flags, entry blocking, clock and
 * power gating outputs, wake request pin.
 * Assumes mclk_i is the always-on PMU clock and the gated system clock
 * is built from sys_clk_en_o outside; firmware picks an internal oscillator.
 */
`include "power_mgmt_map.svh"

module power_mgmt_unit
    import power_mgmt_pkg::*;
#(
    parameter int PIN_HOLD_CYCLES = `PIN_HOLD_CYCLES
) (
    input  wire logic       mclk_i,
    input  wire logic       rst_i,
    input  wire logic       cfg_wr_i,
    input  wire logic [7:0] cfg_wdata_i,
    output logic      [7:0] cfg_rdata_o,
    input  wire wake_src_s  wake_async_i,
    input  wire logic       reset_pin_n_i,
    input  wire logic       two_cell_i,
    input  wire logic       sleep_rail_float_i,
    input  wire logic       battery_monitor_off_wr_i,
    input  wire logic       battery_monitor_off_i,
    input  wire logic       any_reset_i,
    output logic            sys_clk_en_o,
    output logic            osc_en_o,
    output logic            core_regulator_en_o,
    output logic            ram_on_battery_o,
    output logic            analog_rail_tie_o,
    output logic            analog_rail_float_o,
    output logic            gpio_hold_o,
    output logic            port_match_live_o,
    output logic            comparator_live_o,
    output logic            wake_request_o,
    output logic            battery_monitor_en_o,
    output logic            full_por_o,
    output logic            pin_reset_o,
    output power_mode_e     mode_o
);

    // ------------------------------------------------------------
    // Wake event synchronisation
    // ------------------------------------------------------------
    logic [3:0] src_async;
    logic [3:0] src_rise;
    logic       pin_seen;
    logic       pin_ack;

    assign src_async = wake_async_i; // [R4]

    for (genvar g = 0; g < 4; g++) begin : g_sync
        wake_sync u_sync (
            .mclk_i       (mclk_i),
            .rst_i        (rst_i),
            .async_i      (src_async[g]),
            .active_low_i (1'b0),
            .level_o      (),
            .rise_o       (src_rise[g]) // [R25]
        );
    end

    pin_glitch_catch u_pin (
        .mclk_i  (mclk_i),
        .rst_i   (rst_i),
        .pin_n_i (reset_pin_n_i),
        .ack_i   (pin_ack),
        .seen_o  (pin_seen)
    );

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    power_mode_e mode_reg;
    power_mode_e mode_next;
    logic [3:0]  flag_reg;
    logic [3:0]  flag_next;
    logic [3:0]  enable_reg;
    logic [3:0]  enable_next;
    logic        pin_flag_reg;
    logic        pin_flag_next;
    logic        pin_ack_reg;
    logic        pin_ack_next;
    logic [1:0]  blank_reg;
    logic [1:0]  blank_next;
    logic [15:0] hold_reg;
    logic [15:0] hold_next;
    logic        monitor_off_reg;
    logic        monitor_off_next;
    logic        por_reg;
    logic        por_next;
    logic        pin_reset_reg;
    logic        pin_reset_next;
    logic [7:0]  rdata_reg;
    logic [7:0]  rdata_next;

    cfg_write_s  wr;
    logic [3:0]  cmp_ok;
    logic [3:0]  events;
    logic        wake_now;
    logic        blocked;

    always_comb begin
        wr.sleep   = cfg_wdata_i[`CFG_SLEEP_BIT];   // [R23]
        wr.suspend = cfg_wdata_i[`CFG_SUSPEND_BIT];
        wr.clear   = cfg_wdata_i[`CFG_CLEAR_BIT];
        wr.enable  = cfg_wdata_i[3:0];
    end

    // Comparator wake from sleep needs two-cell supply
    assign cmp_ok  = {3'b111, (mode_reg != MODE_SLEEP) | two_cell_i}; // [R17]
    assign events  = src_rise & cmp_ok;
    assign wake_now = ((events & enable_reg) != 4'h0) | pin_seen; // [R3] [R20]
    // Entry blocked by any enabled flag still set
    assign blocked = ((flag_reg & wr.enable) != 4'h0) | pin_flag_reg; // [R22]

    always_comb begin
        mode_next        = mode_reg;
        flag_next        = flag_reg | src_rise; // [R21]
        enable_next      = enable_reg;
        pin_flag_next    = pin_flag_reg | pin_seen;
        pin_ack_next     = pin_seen;
        blank_next       = (blank_reg != 2'd0) ? blank_reg - 2'd1 : 2'd0;
        hold_next        = hold_reg;
        monitor_off_next = monitor_off_reg;
        por_next         = 1'b0;
        pin_reset_next   = 1'b0;

        if (cfg_wr_i && mode_reg == MODE_RUN) begin
            if (wr.clear) begin
                // Set wins over clear
                flag_next     = src_rise;
                pin_flag_next = pin_seen;
            end
            enable_next = wr.enable; // [R24] [R19]
            if ((wr.sleep || wr.suspend) && !blocked && !wr.clear) begin
                mode_next = wr.sleep ? MODE_SLEEP : MODE_SUSPEND; // [R1] [R8]
                hold_next = 16'h0000;
            end
        end

        if (mode_reg != MODE_RUN && wake_now) begin
            if (mode_reg == MODE_SUSPEND) begin
                blank_next = 2'(`WAKE_BLANK_CYCLES); // [R5]
            end
            mode_next = MODE_RUN;
            hold_next = 16'h0000;
        end

        // Pin reset takes effect after staying awake long enough
        if (mode_reg == MODE_RUN && pin_flag_reg) begin
            if (hold_reg < 16'(PIN_HOLD_CYCLES)) begin
                hold_next = hold_reg + 16'h0001;
            end else if (hold_reg == 16'(PIN_HOLD_CYCLES)) begin
                pin_reset_next = 1'b1; // [R20]
                hold_next      = hold_reg + 16'h0001;
            end
        end else if (!pin_flag_reg) begin
            // Restart the awake count for the next pin event
            hold_next = 16'h0000;
        end

        if (battery_monitor_off_wr_i) begin
            monitor_off_next = battery_monitor_off_i; // [R18]
        end
        if (any_reset_i && monitor_off_reg) begin
            por_next         = 1'b1; // [R18]
            monitor_off_next = 1'b0;
        end
    end

    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            mode_reg        <= MODE_RUN;
            flag_reg        <= 4'h0;
            enable_reg      <= 4'h0;
            pin_flag_reg    <= 1'b0;
            pin_ack_reg     <= 1'b0;
            blank_reg       <= 2'd0;
            hold_reg        <= 16'h0000;
            monitor_off_reg <= 1'b0;
            por_reg         <= 1'b0;
            pin_reset_reg   <= 1'b0;
            rdata_reg       <= `CFG_RESET_VALUE;
        end else begin
            mode_reg        <= mode_next;
            flag_reg        <= flag_next;
            enable_reg      <= enable_next;
            pin_flag_reg    <= pin_flag_next;
            pin_ack_reg     <= pin_ack_next;
            blank_reg       <= blank_next;
            hold_reg        <= hold_next;
            monitor_off_reg <= monitor_off_next;
            por_reg         <= por_next;
            pin_reset_reg   <= pin_reset_next;
            rdata_reg       <= rdata_next;
        end
    end

    assign pin_ack = pin_ack_reg;

    // ------------------------------------------------------------
    // Read back and power controls
    // ------------------------------------------------------------
    always_comb begin
        if (blank_next != 2'd0) begin
            rdata_next = `CFG_RESET_VALUE; // [R5]
        end else begin
            rdata_next = {3'b000, pin_flag_next, flag_next}; // [R24]
        end
    end

    assign cfg_rdata_o          = rdata_reg;

    assign sys_clk_en_o         = (mode_reg == MODE_RUN); // [R1] [R3]
    assign osc_en_o             = (mode_reg == MODE_RUN);
    assign core_regulator_en_o  = (mode_reg != MODE_SLEEP); // [R8] [R16]
    assign ram_on_battery_o     = (mode_reg == MODE_SLEEP);
    assign analog_rail_tie_o    = (mode_reg == MODE_SLEEP) &
                                  ~sleep_rail_float_i; // [R15]
    assign analog_rail_float_o  = (mode_reg == MODE_SLEEP) &
                                  sleep_rail_float_i;
    assign gpio_hold_o          = (mode_reg == MODE_SLEEP); // [R12]
    assign port_match_live_o    = 1'b1; // [R13]
    assign comparator_live_o    = (mode_reg != MODE_SLEEP) |
                                  two_cell_i; // [R9]
    assign wake_request_o       = (mode_reg != MODE_SLEEP); // [R14]
    assign battery_monitor_en_o = ~monitor_off_reg;
    assign full_por_o           = por_reg;
    assign pin_reset_o          = pin_reset_reg;
    assign mode_o               = mode_reg;

endmodule

// ---- logic/wake_sync.sv ----
/*
 * Two-flop synchroniser with a rising-edge pulse taken after the second
 * flop. Assumes the input is asynchronous to the clock.
 */
module wake_sync (
    input  wire logic mclk_i,
    input  wire logic rst_i,
    input  wire logic async_i,
    input  wire logic active_low_i,
    output logic      level_o,
    output logic      rise_o
);

    logic meta_reg;
    logic stable_reg;
    logic last_reg;
    logic meta_next;
    logic stable_next;
    logic last_next;

    always_comb begin
        meta_next   = async_i ^ active_low_i;
        stable_next = meta_reg;
        last_next   = stable_reg;
    end

    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            meta_reg   <= 1'b0;
            stable_reg <= 1'b0;
            last_reg   <= 1'b0;
        end else begin
            meta_reg   <= meta_next;
            stable_reg <= stable_next;
            last_reg   <= last_next;
        end
    end

    assign level_o = stable_reg;
    assign rise_o  = stable_reg & ~last_reg;

endmodule

// ---- tb/power_mgmt_chk.sv ----
/* Port assertions for the power management unit.
   Bound to power_mgmt_unit; sees only its ports. */
module power_mgmt_chk
    import power_mgmt_pkg::*;
#(
    parameter int PIN_HOLD_CYCLES = 1500
) (
    input wire logic        mclk_i,
    input wire logic        rst_i,
    input wire logic        cfg_wr_i,
    input wire logic [7:0]  cfg_wdata_i,
    input wire logic [7:0]  cfg_rdata_o,
    input wire logic        two_cell_i,
    input wire logic        sleep_rail_float_i,
    input wire logic        any_reset_i,
    input wire logic        sys_clk_en_o,
    input wire logic        osc_en_o,
    input wire logic        core_regulator_en_o,
    input wire logic        ram_on_battery_o,
    input wire logic        gpio_hold_o,
    input wire logic        analog_rail_float_o,
    input wire logic        analog_rail_tie_o,
    input wire logic        port_match_live_o,
    input wire logic        comparator_live_o,
    input wire logic        wake_request_o,
    input wire logic        battery_monitor_en_o,
    input wire logic        full_por_o,
    input wire logic        pin_reset_o,
    input wire power_mode_e mode_o
);
    timeunit 1ns;
    timeprecision 100ps;

    // ------------------------------------------------------------
    // Awake time counter and checks
    // ------------------------------------------------------------
    logic [1:0] awake_reg;
    logic [1:0] awake_next;
    logic       block;

    always_comb begin
        awake_next = awake_reg + {1'b0, awake_reg != 2'h3};
        if (mode_o != MODE_RUN) begin
            awake_next = 2'h0;
        end
    end

    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            awake_reg <= 2'h3;
        end else begin
            awake_reg <= awake_next;
        end
    end

    assign block = (cfg_rdata_o[4:0] & {1'b1, cfg_wdata_i[3:0]}) != 5'h00;

    default clocking @(posedge mclk_i); endclocking
    default disable iff (rst_i);

    clk_gate_a: assert property (
        sys_clk_en_o == (mode_o == MODE_RUN) && osc_en_o == sys_clk_en_o)
        else $error("clock gating wrong");
    entry_ok_a: assert property (
        cfg_wr_i && mode_o == MODE_RUN && awake_reg == 2'h3
        && cfg_wdata_i[7:5] == 3'h2 && !block |=> mode_o == MODE_SUSPEND)
        else $error("suspend entry lost");
    entry_block_a: assert property (
        cfg_wr_i && mode_o == MODE_RUN && (cfg_wdata_i[5] || block)
        |=> mode_o == MODE_RUN) else $error("blocked entry taken");
    flag_blank_a: assert property (
        $past(mode_o) == MODE_SUSPEND && mode_o == MODE_RUN
        |-> cfg_rdata_o == 8'h00 ##1 cfg_rdata_o == 8'h00)
        else $error("flags not blanked");
    sleep_power_a: assert property (
        mode_o == MODE_SLEEP |-> !core_regulator_en_o && ram_on_battery_o
        && gpio_hold_o && port_match_live_o)
        else $error("sleep power state wrong");
    wake_req_a: assert property (
        wake_request_o == (mode_o != MODE_SLEEP))
        else $error("wake request wrong");
    rail_float_a: assert property (
        analog_rail_float_o == (mode_o == MODE_SLEEP && sleep_rail_float_i)
        && analog_rail_tie_o
        == (mode_o == MODE_SLEEP && !sleep_rail_float_i))
        else $error("rail float wrong");
    cmp_live_a: assert property (
        comparator_live_o == !(mode_o == MODE_SLEEP && !two_cell_i))
        else $error("cmp live");
    pin_reset_a: assert property (
        pin_reset_o |-> mode_o == MODE_RUN && cfg_rdata_o[4])
        else $error("pin reset");
    full_por_a: assert property (
        any_reset_i && !battery_monitor_en_o |-> ##[1:2] full_por_o)
        else $error("full por missing");

    cover property (mode_o == MODE_SUSPEND);
    cover property (mode_o == MODE_SLEEP && !two_cell_i);
    cover property (pin_reset_o);
endmodule

bind power_mgmt_unit power_mgmt_chk #(
    .PIN_HOLD_CYCLES(PIN_HOLD_CYCLES)
) u_chk (
    .mclk_i(mclk_i), .rst_i(rst_i), .cfg_wr_i(cfg_wr_i),
    .cfg_wdata_i(cfg_wdata_i), .cfg_rdata_o(cfg_rdata_o),
    .two_cell_i(two_cell_i), .sleep_rail_float_i(sleep_rail_float_i),
    .any_reset_i(any_reset_i), .sys_clk_en_o(sys_clk_en_o),
    .osc_en_o(osc_en_o), .core_regulator_en_o(core_regulator_en_o),
    .ram_on_battery_o(ram_on_battery_o), .gpio_hold_o(gpio_hold_o),
    .analog_rail_float_o(analog_rail_float_o),
    .analog_rail_tie_o(analog_rail_tie_o),
    .port_match_live_o(port_match_live_o),
    .comparator_live_o(comparator_live_o), .wake_request_o(wake_request_o),
    .battery_monitor_en_o(battery_monitor_en_o), .full_por_o(full_por_o),
    .pin_reset_o(pin_reset_o), .mode_o(mode_o));

// ---- tb/power_mgmt_unit_tb_top.sv ----
/* Self-checking bench for the power management unit.
   Uses the wake source model; checker bound separately. */
module power_mgmt_unit_tb_top
    import power_mgmt_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;

    logic mclk_i = 0, rst_i = 1, cfg_wr_i = 0, pin_n;
    logic mon_wr = 0, mon_off = 0, two_cell = 1, rail_float = 0;
    logic any_rst = 0, por_seen = 0, pin_seen = 0;
    logic [7:0] cfg_wdata = 8'h00, cfg_rdata_o;
    logic [4:0] kick = 5'h00;
    logic sys_clk_en_o, rail_f_o, cmp_live_o, wake_req_o;
    logic mon_en_o, por_o, pin_o;
    wake_src_s wake;
    power_mode_e mode_o;
    int mismatches = 0, num_checks = 0;

    always #5 mclk_i = ~mclk_i;
    always @(posedge mclk_i) begin
        por_seen <= por_seen | por_o;
        pin_seen <= pin_seen | pin_o;
    end

    wake_src_model src (.mclk_i(mclk_i), .kick_i(kick), .wake_o(wake),
        .pin_n_o(pin_n));

    power_mgmt_unit #(.PIN_HOLD_CYCLES(10)) dut (.mclk_i(mclk_i),
        .rst_i(rst_i), .cfg_wr_i(cfg_wr_i), .cfg_wdata_i(cfg_wdata),
        .cfg_rdata_o(cfg_rdata_o), .wake_async_i(wake), .reset_pin_n_i(pin_n),
        .two_cell_i(two_cell), .sleep_rail_float_i(rail_float),
        .battery_monitor_off_wr_i(mon_wr), .battery_monitor_off_i(mon_off),
        .any_reset_i(any_rst), .sys_clk_en_o(sys_clk_en_o), .osc_en_o(),
        .core_regulator_en_o(), .ram_on_battery_o(), .analog_rail_tie_o(),
        .analog_rail_float_o(rail_f_o), .gpio_hold_o(), .port_match_live_o(),
        .comparator_live_o(cmp_live_o), .wake_request_o(wake_req_o),
        .battery_monitor_en_o(mon_en_o), .full_por_o(por_o),
        .pin_reset_o(pin_o), .mode_o(mode_o));

    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task automatic check(input string what, input logic [7:0] exp,
                         input logic [7:0] got);
        num_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic cfg_write(input logic [7:0] d);
        @(negedge mclk_i);
        cfg_wr_i = 1'b1;
        cfg_wdata = d;
        @(negedge mclk_i);
        cfg_wr_i = 1'b0;
    endtask

    task automatic fire(input int i);
        @(negedge mclk_i);
        kick[i] = 1'b1;
        repeat (2) @(negedge mclk_i);
        kick[i] = 1'b0;
        repeat (8) @(negedge mclk_i);
    endtask

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    initial begin
        #100us;
        mismatches++;
        end_of_test();
    end

    // ------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------
    initial begin
        repeat (16) @(negedge mclk_i);
        rst_i = 1'b0;
        check("rdata", 8'h00, cfg_rdata_o);
        check("wake_req", 8'h01, {7'h00, wake_req_o});
        fire(2);
        check("unenabled flag", 8'h04, cfg_rdata_o);
        cfg_write(8'h20);
        check("clear", 8'h00, cfg_rdata_o);
        $display("test flags done");
        fire(2);
        cfg_write(8'h44);
        check("blocked", 8'(MODE_RUN), 8'(mode_o));
        cfg_write(8'h48);
        check("suspend", 8'(MODE_SUSPEND), 8'(mode_o));
        check("clk gated", 8'h00, {7'h00, sys_clk_en_o});
        fire(3);
        check("resume", 8'(MODE_RUN), 8'(mode_o));
        check("suspend flags", 8'h0c, cfg_rdata_o);
        cfg_write(8'h20);
        $display("test suspend done");
        for (int i = 0; i < 4; i++) begin
            rail_float = i[0];
            cfg_write(8'h80 | (8'h01 << i));
            repeat (4) @(negedge mclk_i);
            check("sleep", 8'(MODE_SLEEP), 8'(mode_o));
            check("rail", {7'h00, i[0]}, {7'h00, rail_f_o});
            check("wake_req low", 8'h00, {7'h00, wake_req_o});
            fire(i);
            check("woke", 8'(MODE_RUN), 8'(mode_o));
            check("source flag", 8'h01 << i, cfg_rdata_o);
            cfg_write(8'h20);
        end
        $display("test sleep sources done");
        two_cell = 1'b0;
        cfg_write(8'h8f);
        fire(0);
        check("one-cell cmp", 8'(MODE_SLEEP), 8'(mode_o));
        check("cmp live", 8'h00, {7'h00, cmp_live_o});
        fire(4);
        check("pin wake", 8'(MODE_RUN), 8'(mode_o));
        check("pin flags", 8'h11, cfg_rdata_o);
        cfg_write(8'h42);
        check("pin blocks", 8'(MODE_RUN), 8'(mode_o));
        repeat (15) @(negedge mclk_i);
        check("pin reset", 8'h01, {7'h00, pin_seen});
        cfg_write(8'h20);
        two_cell = 1'b1;
        $display("test pin wake done");
        mon_wr = 1'b1;
        mon_off = 1'b1;
        @(negedge mclk_i);
        mon_wr = 1'b0;
        @(negedge mclk_i);
        check("monitor off", 8'h00, {7'h00, mon_en_o});
        any_rst = 1'b1;
        @(negedge mclk_i);
        any_rst = 1'b0;
        repeat (3) @(negedge mclk_i);
        check("full por", 8'h01, {7'h00, por_seen});
        check("monitor on", 8'h01, {7'h00, mon_en_o});
        $display("test monitor done");
        end_of_test();
    end
endmodule

// ---- tb/wake_src_model.sv ----
/* Wake sources outside the power unit: four event levels, reset pin.
   Kick bits come from the bench at the falling clock edge. */
module wake_src_model
    import power_mgmt_pkg::*;
(
    input  wire logic       mclk_i,
    input  wire logic [4:0] kick_i,
    output wake_src_s       wake_o,
    output logic            pin_n_o
);
    timeunit 1ns;
    timeprecision 100ps;

    initial begin
        wake_o = '0;
        pin_n_o = 1'b1;
    end

    // Event levels change off the clock edge
    always @(posedge mclk_i) begin
        wake_o <= #3 kick_i[3:0];
    end

    // Reset pin glitch far shorter than a clock period
    always @(posedge kick_i[4]) begin
        #2 pin_n_o = 1'b0;
        #2 pin_n_o = 1'b1;
    end
endmodule
